// File: src/cadec_decoder.sv
// control-arithmetic instruction decoder, one registered decode per valid word
// Behaviour
// - 0001110 with bit21=0: direct move, register 20:16, address 15:0.
// - 0001111 with bit21=1: pointer move, reverse bit10, pointer 9:5, increment 4:0.
// - 0001111, bit21=0, pointer 00000: I/O register 4:0, general register 20:16.
// - 0001110 with bit21=1: memory-to-I/O, I/O register 20:16, pointer, increment.
// - top 101: branch to register plus 24-bit offset from 28:21 and 15:0.
// - top 110: load register 20:16 with 24-bit immediate.
// - top 111: call 24-bit address, return address into register 20:16.
// - condition groups 00 flag, 01 data unit, 10 I/O; 01101-01111 reserved.
// - register-source ALU uses only three low condition bits, flag group.
// - direction 0 loads register from memory, 1 stores register.
// - operand-count 0 two operands, 1 three with register source.
// - conditional bit 0 unconditional, 1 only when condition holds.
// - width selects high byte, low byte, 16-bit or 32-bit.
// - branch sense 0 takes on false condition, 1 on true.
// - functions 0000-0110: add, x2, rsub, carry-reverse add, sub, negate, andc.
// - functions 0111 and 1111 only update flags, no destination write.
// - functions 1000-1110: xor, rotr, or, rotl, shr, div2, and.
// - register selector map, 11100 and 11111 reserved.
// - pointer selector 00000 selects I/O form; reserved codes listed.
// - I/O register selector addresses ibuf, obuf, pdr, piop, pdr2, pir, pcw.
`timescale 1ns/1ps
`default_nettype none
module cadec_decoder
  import cadec_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        instr_valid_i,
  input  wire logic [31:0] instr_i,
  output logic             dec_valid_o,
  output cadec_kind_t      kind_o,
  output logic             illegal_o,
  output logic             write_en_o,
  output logic [4:0]       reg_sel_o,
  output logic [4:0]       src1_sel_o,
  output logic [4:0]       src2_sel_o,
  output logic [4:0]       ptr_sel_o,
  output logic [4:0]       inc_sel_o,
  output logic [4:0]       io_sel_o,
  output logic             bit_reverse_o,
  output logic             to_memory_o,
  output cadec_width_t     width_o,
  output logic [15:0]      addr_o,
  output logic [23:0]      imm24_o,
  output logic [4:0]       cond_o,
  output logic [1:0]       cond_group_o,
  output logic             cond_exec_o,
  output logic             branch_sense_o,
  output logic             three_operand_o,
  output cadec_func_t      func_o,
  output logic             store_result_o
);
  typedef struct packed {
    logic         valid;
    cadec_kind_t  kind;
    logic         illegal;
    logic         write_en;
    logic [4:0]   reg_sel;
    logic [4:0]   src1;
    logic [4:0]   src2;
    logic [4:0]   ptr;
    logic [4:0]   inc;
    logic [4:0]   io;
    logic         rev;
    logic         to_mem;
    cadec_width_t width;
    logic [15:0]  addr;
    logic [23:0]  imm;
    logic [4:0]   cond;
    logic [1:0]   cgrp;
    logic         cexec;
    logic         sense;
    logic         three;
    cadec_func_t  func;
    logic         store;
  } cadec_state_t;

  cadec_state_t state_reg;
  cadec_state_t state_next;

  // named fields of the fetched word; each form gives them its own meaning
  logic [2:0]  op_top3;
  logic [6:0]  op_top7;
  logic        fld_dir;
  logic [1:0]  fld_width;
  logic        fld_form;
  logic [4:0]  fld_dest;
  logic [15:0] fld_addr;
  logic [7:0]  fld_imm_high;
  logic [4:0]  fld_cond;
  logic [3:0]  fld_func;
  logic        fld_imm_src;
  logic [2:0]  fld_alu_cond;
  logic        fld_alu_sense;
  logic        fld_three;
  logic        fld_cexec;
  logic        fld_rev;
  logic [4:0]  fld_ptr;
  logic [4:0]  fld_low;

  assign op_top3       = instr_i[31:29];
  assign op_top7       = instr_i[31:25];
  assign fld_dir       = instr_i[24];
  assign fld_width     = instr_i[23:22];
  assign fld_form      = instr_i[21];
  assign fld_dest      = instr_i[20:16];
  assign fld_addr      = instr_i[15:0];
  assign fld_imm_high  = instr_i[28:21];
  assign fld_cond      = instr_i[26:22];
  assign fld_func      = instr_i[24:21];
  assign fld_imm_src   = instr_i[25];
  assign fld_alu_cond  = instr_i[15:13];
  assign fld_alu_sense = instr_i[12];
  assign fld_three     = instr_i[11];
  assign fld_cexec     = instr_i[10];
  assign fld_rev       = instr_i[10];
  assign fld_ptr       = instr_i[9:5];
  assign fld_low       = instr_i[4:0];

  // opcode classes; the long forms own the top three bits outright
  logic is_branch;
  logic is_loadi;
  logic is_call;
  logic is_move_dir;
  logic is_move_ptr;
  logic is_cond_branch;
  logic is_alu;

  assign is_branch      = (op_top3 == CADEC_BRANCH_OP);
  assign is_loadi       = (op_top3 == CADEC_LOADI_OP);
  assign is_call        = (op_top3 == CADEC_CALL_OP);
  assign is_move_dir    = (op_top7 == CADEC_MOVE_DIR_OP);
  assign is_move_ptr    = (op_top7 == CADEC_MOVE_PTR_OP);
  assign is_cond_branch = (instr_i[31:27] == 5'h00);
  assign is_alu         = (instr_i[30:26] == CADEC_ALU_OP6[4:0]);

  // only these two codes have no register behind them
  function automatic logic reg_bad(input logic [4:0] r);
    case (r)
      CADEC_REG_RSV0: reg_bad = 1'b1;
      CADEC_REG_RSV1: reg_bad = 1'b1;
      default:        reg_bad = 1'b0;
    endcase
  endfunction

  // 00000 is absent on purpose: it picks the I/O form, the caller decides
  function automatic logic ptr_bad(input logic [4:0] p);
    case (p)
      5'h0f:   ptr_bad = 1'b1;
      5'h10:   ptr_bad = 1'b1;
      5'h16:   ptr_bad = 1'b1;
      5'h17:   ptr_bad = 1'b1;
      5'h1a:   ptr_bad = 1'b1;
      5'h1b:   ptr_bad = 1'b1;
      5'h1c:   ptr_bad = 1'b1;
      5'h1e:   ptr_bad = 1'b1;
      5'h1f:   ptr_bad = 1'b1;
      default: ptr_bad = 1'b0;
    endcase
  endfunction

  function automatic logic io_bad(input logic [4:0] r);
    case (r)
      CADEC_IO_IBUF: io_bad = 1'b0;
      CADEC_IO_OBUF: io_bad = 1'b0;
      CADEC_IO_PDR:  io_bad = 1'b0;
      CADEC_IO_PIOP: io_bad = 1'b0;
      CADEC_IO_PDR2: io_bad = 1'b0;
      CADEC_IO_PIR:  io_bad = 1'b0;
      CADEC_IO_PCW:  io_bad = 1'b0;
      default:       io_bad = 1'b1;
    endcase
  endfunction

  function automatic logic cond_bad(input logic [4:0] c);
    case (c[4:3])
      CADEC_CGRP_CA: cond_bad = 1'b0;
      CADEC_CGRP_DA: cond_bad = (c > CADEC_C_DA_MAX);
      CADEC_CGRP_IO: cond_bad = 1'b0;
      default:       cond_bad = 1'b1; // group 11 holds no conditions
    endcase
  endfunction

  always_comb begin
    logic bad;
    bad        = 1'b0;
    state_next = state_reg;
    state_next.valid   = instr_valid_i;
    if (instr_valid_i) begin
      state_next.kind    = CADEC_K_OTHER;
      state_next.reg_sel = fld_dest;
      state_next.src1    = fld_ptr;
      state_next.src2    = fld_low;
      state_next.ptr     = fld_ptr;
      state_next.inc     = fld_low;
      state_next.io      = 5'h00;
      state_next.rev     = fld_rev;
      state_next.to_mem  = fld_dir;
      state_next.width   = cadec_width_t'(fld_width);
      state_next.addr    = fld_addr;
      state_next.imm     = {fld_imm_high, fld_addr};
      state_next.cond    = fld_cond;
      state_next.cgrp    = fld_cond[4:3];
      state_next.cexec   = 1'b0;
      state_next.sense   = fld_form;
      state_next.three   = 1'b0;
      state_next.func    = cadec_func_t'(fld_func);
      state_next.store   = 1'b0;
      state_next.write_en = 1'b0;
      if (is_branch) begin
        state_next.kind = CADEC_K_BRANCH;
        bad = reg_bad(fld_dest);
      end else if (is_loadi) begin
        state_next.kind     = CADEC_K_LOADI;
        state_next.write_en = 1'b1;
        bad = reg_bad(fld_dest);
      end else if (is_call) begin
        state_next.kind     = CADEC_K_CALL;
        state_next.write_en = 1'b1;
        bad = reg_bad(fld_dest);
      end else if (is_move_dir) begin
        if (!fld_form) begin
          state_next.kind = CADEC_K_MOVE_DIR;
          bad = reg_bad(fld_dest);
        end else begin
          state_next.kind    = CADEC_K_MEM_TO_IO;
          state_next.io      = fld_dest;
          state_next.reg_sel = 5'h00;
          bad = io_bad(fld_dest) || ptr_bad(fld_ptr) || (fld_ptr == CADEC_PTR_IO);
        end
        state_next.write_en = !fld_dir;
      end else if (is_move_ptr) begin
        if (fld_form) begin
          state_next.kind = CADEC_K_MOVE_PTR;
          bad = reg_bad(fld_dest) || ptr_bad(fld_ptr) || (fld_ptr == CADEC_PTR_IO);
        end else if (fld_ptr == CADEC_PTR_IO) begin
          state_next.kind = CADEC_K_MOVE_IO;
          state_next.io   = fld_low;
          bad = reg_bad(fld_dest) || io_bad(fld_low);
        end else begin
          bad = 1'b1;
        end
        state_next.write_en = !fld_dir;
      end else if (is_cond_branch) begin
        state_next.kind = CADEC_K_BCOND;
        bad = cond_bad(fld_cond) || reg_bad(fld_dest);
      end else if (is_alu) begin
        state_next.func     = cadec_func_t'(fld_func);
        state_next.store    = (fld_func != CADEC_F_CMP) && (fld_func != CADEC_F_ANDNS);
        state_next.write_en = state_next.store;
        if (!fld_imm_src) begin
          state_next.kind  = CADEC_K_ALU_REG;
          state_next.cond  = {2'h0, fld_alu_cond};
          state_next.cgrp  = CADEC_CGRP_CA;
          state_next.three = fld_three;
          state_next.cexec = fld_cexec;
          state_next.sense = fld_alu_sense;
          bad = reg_bad(fld_dest) || reg_bad(fld_ptr) || (fld_three && reg_bad(fld_low));
        end else begin
          state_next.kind = CADEC_K_ALU_IMM;
          bad = reg_bad(fld_dest);
        end
      end
      state_next.illegal = bad;
      if (bad) begin
        state_next.write_en = 1'b0;
        state_next.store    = 1'b0;
      end
    end else begin
      state_next.kind     = CADEC_K_NONE;
      state_next.illegal  = 1'b0;
      state_next.write_en = 1'b0;
      state_next.store    = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dec_valid_o     = state_reg.valid;
  assign kind_o          = state_reg.kind;
  assign illegal_o       = state_reg.illegal;
  assign write_en_o      = state_reg.write_en;
  assign reg_sel_o       = state_reg.reg_sel;
  assign src1_sel_o      = state_reg.src1;
  assign src2_sel_o      = state_reg.src2;
  assign ptr_sel_o       = state_reg.ptr;
  assign inc_sel_o       = state_reg.inc;
  assign io_sel_o        = state_reg.io;
  assign bit_reverse_o   = state_reg.rev;
  assign to_memory_o     = state_reg.to_mem;
  assign width_o         = state_reg.width;
  assign addr_o          = state_reg.addr;
  assign imm24_o         = state_reg.imm;
  assign cond_o          = state_reg.cond;
  assign cond_group_o    = state_reg.cgrp;
  assign cond_exec_o     = state_reg.cexec;
  assign branch_sense_o  = state_reg.sense;
  assign three_operand_o = state_reg.three;
  assign func_o          = state_reg.func;
  assign store_result_o  = state_reg.store;
endmodule
`default_nettype wire

// File: src/cadec_pkg.sv
// constants and types for the control-arithmetic instruction decoder
package cadec_pkg;
  localparam logic [6:0] CADEC_MOVE_DIR_OP = 7'h0e;
  localparam logic [6:0] CADEC_MOVE_PTR_OP = 7'h0f;
  localparam logic [3:0] CADEC_ALU_OP      = 4'h3;
  localparam logic [5:0] CADEC_ALU_OP6     = 6'h06;
  localparam logic [2:0] CADEC_BRANCH_OP   = 3'h5;
  localparam logic [2:0] CADEC_LOADI_OP    = 3'h6;
  localparam logic [2:0] CADEC_CALL_OP     = 3'h7;
  localparam logic [4:0] CADEC_PTR_IO      = 5'h00;
  localparam logic [1:0] CADEC_CGRP_CA     = 2'h0;
  localparam logic [1:0] CADEC_CGRP_DA     = 2'h1;
  localparam logic [1:0] CADEC_CGRP_IO     = 2'h2;
  localparam logic [4:0] CADEC_C_DA_MAX    = 5'h0c;
  localparam logic [3:0] CADEC_F_CMP       = 4'h7;
  localparam logic [3:0] CADEC_F_ANDNS     = 4'hf;
  localparam logic [4:0] CADEC_REG_RSV0    = 5'h1c;
  localparam logic [4:0] CADEC_REG_RSV1    = 5'h1f;
  localparam logic [4:0] CADEC_IO_IBUF     = 5'h04;
  localparam logic [4:0] CADEC_IO_OBUF     = 5'h05;
  localparam logic [4:0] CADEC_IO_PDR      = 5'h06;
  localparam logic [4:0] CADEC_IO_PIOP     = 5'h0e;
  localparam logic [4:0] CADEC_IO_PDR2     = 5'h14;
  localparam logic [4:0] CADEC_IO_PIR      = 5'h16;
  localparam logic [4:0] CADEC_IO_PCW      = 5'h1e;
  typedef enum logic [3:0] {
    CADEC_K_NONE, CADEC_K_BCOND, CADEC_K_MOVE_DIR, CADEC_K_MOVE_PTR, CADEC_K_MOVE_IO,
    CADEC_K_MEM_TO_IO, CADEC_K_ALU_REG, CADEC_K_ALU_IMM, CADEC_K_BRANCH, CADEC_K_LOADI,
    CADEC_K_CALL, CADEC_K_OTHER
  } cadec_kind_t;
  typedef enum logic [3:0] {
    CADEC_F_ADD, CADEC_F_MUL2, CADEC_F_RSUB, CADEC_F_CRADD, CADEC_F_SUB, CADEC_F_NEG,
    CADEC_F_ANDC, CADEC_F_COMPARE, CADEC_F_XOR, CADEC_F_RORC, CADEC_F_OR, CADEC_F_ROLC,
    CADEC_F_SHR, CADEC_F_DIV2, CADEC_F_AND, CADEC_F_TEST
  } cadec_func_t;
  typedef enum logic [1:0] {
    CADEC_W_HIGH_BYTE, CADEC_W_LOW_BYTE, CADEC_W_INT16, CADEC_W_WORD32
  } cadec_width_t;
endpackage

// File: verif/cadec_seq_model.sv
// program sequencer model handing fetched words to the decoder
`timescale 1ns/1ps
`default_nettype none
module cadec_seq_model (
  input  wire logic        mclk_i,
  input  wire logic        send_i,
  input  wire logic [31:0] word_i,
  output logic             instr_valid_o,
  output logic [31:0]      instr_o
);
  initial begin
    instr_valid_o = 1'b0;
    instr_o       = 32'h0;
  end
  // idle bus inverts its previous value each cycle, so the last word comes back every second idle cycle
  always @(negedge mclk_i) begin
    instr_valid_o <= send_i;
    instr_o       <= send_i ? word_i : ~instr_o;
  end
endmodule
`default_nettype wire

// File: verif/cadec_decoder_asserts.sv
// port assertions for the decoder
`timescale 1ns/1ps
`default_nettype none
module cadec_decoder_asserts
  import cadec_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic        instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic        dec_valid_o,
  input wire cadec_kind_t kind_o,
  input wire logic        illegal_o,
  input wire logic        write_en_o,
  input wire logic        store_result_o,
  input wire logic [15:0] addr_o,
  input wire logic [23:0] imm24_o,
  input wire logic [1:0]  cond_group_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire [6:0]  op7    = instr_i[31:25];
  wire [23:0] imm_in = {instr_i[28:21], instr_i[15:0]};
  a_answer_next: assert property (dec_valid_o == $past(instr_valid_i))
    else $error("decode strobe off");
  a_direct_move: assert property (instr_valid_i && op7 == CADEC_MOVE_DIR_OP && !instr_i[21] |=>
    kind_o == CADEC_K_MOVE_DIR && addr_o == $past(instr_i[15:0])) else $error("direct move bad");
  a_mem_to_io: assert property (instr_valid_i && op7 == CADEC_MOVE_DIR_OP && instr_i[21] |=>
    kind_o == CADEC_K_MEM_TO_IO) else $error("memory to io bad");
  a_long_imm: assert property (instr_valid_i && instr_i[31] && instr_i[30:29] != 2'h0 |=>
    imm24_o == $past(imm_in)) else $error("long immediate bad");
  a_flag_only: assert property (instr_valid_i && instr_i[30:26] == 5'h06 && instr_i[23:21] == 3'h7 |=>
    !write_en_o) else $error("flag-only function wrote");
  a_illegal_quiet: assert property (illegal_o |-> !write_en_o && !store_result_o)
    else $error("illegal word changes state");
  a_cond_group: assert property (instr_valid_i && instr_i[31:27] == 5'h00 |=>
    cond_group_o == $past(instr_i[26:25])) else $error("condition group bad");
  a_reg_rsv: assert property (instr_valid_i && op7[6:4] == CADEC_LOADI_OP && instr_i[20:16] inside {5'h1c, 5'h1f} |=>
    illegal_o) else $error("reserved register taken");
endmodule
bind cadec_decoder cadec_decoder_asserts chk_u (
  .mclk_i         (mclk_i),
  .reset_n_i      (reset_n_i),
  .instr_valid_i  (instr_valid_i),
  .instr_i        (instr_i),
  .dec_valid_o    (dec_valid_o),
  .kind_o         (kind_o),
  .illegal_o      (illegal_o),
  .write_en_o     (write_en_o),
  .store_result_o (store_result_o),
  .addr_o         (addr_o),
  .imm24_o        (imm24_o),
  .cond_group_o   (cond_group_o)
);
`default_nettype wire

// File: verif/tb_control_arith_instr_decoder.sv
// self-checking bench for the decoder
`timescale 1ns/1ps
`default_nettype none
module tb_control_arith_instr_decoder;
  import cadec_pkg::*;
  logic         mclk_i, reset_n_i, send, vld, dv, ill, we, st, rev, tom, ce, bs, three;
  logic [31:0]  word, instr;
  logic [4:0]   regs, s1, s2, ptr, inc, io, cond;
  logic [15:0]  addr;
  logic [23:0]  imm;
  logic [1:0]   cg;
  cadec_kind_t  kind;
  cadec_width_t wid;
  cadec_func_t  fn;
  int           fail_count, n_tests;
  cadec_seq_model seq_u (.mclk_i(mclk_i), .send_i(send), .word_i(word), .instr_valid_o(vld), .instr_o(instr));
  cadec_decoder dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .instr_valid_i(vld), .instr_i(instr),
    .dec_valid_o(dv), .kind_o(kind), .illegal_o(ill), .write_en_o(we), .reg_sel_o(regs), .src1_sel_o(s1),
    .src2_sel_o(s2), .ptr_sel_o(ptr), .inc_sel_o(inc), .io_sel_o(io), .bit_reverse_o(rev), .to_memory_o(tom),
    .width_o(wid), .addr_o(addr), .imm24_o(imm), .cond_o(cond), .cond_group_o(cg), .cond_exec_o(ce),
    .branch_sense_o(bs), .three_operand_o(three), .func_o(fn), .store_result_o(st));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one word per call; the two gap cycles let the idle bus show junk
  task automatic issue(input logic [31:0] w);
    @(negedge mclk_i);
    send <= 1'b1;
    word <= w;
    @(negedge mclk_i);
    send <= 1'b0;
    @(negedge mclk_i);
    chk("strobe", 1'b1, dv);
  endtask
  task automatic t_moves;
    issue(32'h1dc3beef);
    chk("direct", {CADEC_K_MOVE_DIR,5'h03,16'hbeef,1'b1,CADEC_W_WORD32}, {kind,regs,addr,tom,wid});
    issue(32'h1c430000);
    chk("direct load", {1'b0,CADEC_W_LOW_BYTE,1'b1}, {tom,wid,we});
    issue(32'h1e250451);
    chk("pointer", {CADEC_K_MOVE_PTR,5'h05,5'h02,5'h11,1'b1,CADEC_W_HIGH_BYTE}, {kind,regs,ptr,inc,rev,wid});
    issue(32'h1f070006);
    chk("io move", {CADEC_K_MOVE_IO,5'h07,5'h06,1'b1}, {kind,regs,io,tom});
    issue(32'h1db60317);
    chk("mem to io", {CADEC_K_MEM_TO_IO,5'h16,5'h18,5'h17,CADEC_W_INT16}, {kind,io,ptr,inc,wid});
  endtask
  task automatic t_long;
    issue(32'ha2443456);
    chk("branch", {CADEC_K_BRANCH,24'h123456,5'h04}, {kind,imm,regs});
    issue(32'hc2443456);
    chk("load imm", {CADEC_K_LOADI,24'h123456,5'h04,1'b1}, {kind,imm,regs,we});
    issue(32'he2510004);
    chk("call", {CADEC_K_CALL,24'h120004,5'h11,1'b1}, {kind,imm,regs,we});
  endtask
  // odd codes also flip sense, operand count and conditional bits
  task automatic t_alu;
    for (int f = 0; f < 16; f++) begin
      issue({7'h0c, f[3:0], 5'h01, 3'h2, {3{f[0]}}, 5'h02, 5'h03});
      chk("alu", {CADEC_K_ALU_REG,f[3:0],{2{f[2:0]!=3'h7}},5'h02,2'h0,{3{f[0]}},5'h02,5'h03},
        {kind, fn, we, st, cond, cg, bs, three, ce, s1, s2});
    end
    issue({7'h4d, 4'hf, 5'h02, 16'h1234});
    chk("alu imm", {CADEC_K_ALU_IMM, CADEC_F_TEST, 2'h0, 5'h02, 16'h1234}, {kind, fn, we, st, regs, addr});
  endtask
  task automatic t_selectors;
    for (int v = 0; v < 32; v++) begin
      issue({5'h00, v[4:0], 1'b1, 5'h01, 16'h0000});
      chk("cond sel", {CADEC_K_BCOND, v[4:0], v[4:3], 1'b1, (v inside {[13:15], [24:31]})},
        {kind, cond, cg, bs, ill});
      issue({3'h6, 8'h00, v[4:0], 16'h0000});
      chk("reg sel", {v[4:0], (v inside {28, 31}), !(v inside {28, 31})}, {regs, ill, we});
      issue({7'h0f, 4'h1, 5'h01, 6'h00, v[4:0], 5'h01});
      chk("ptr sel", {v[4:0], !(v inside {[1:14], [17:21], 24, 25, 29})}, {ptr, ill});
      issue({7'h0f, 4'h0, 5'h01, 11'h000, v[4:0]});
      chk("io sel", {v[4:0], !(v inside {4, 5, 6, 14, 20, 22, 30})}, {io, ill});
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    #50000;
    fail_count++;
    test_done;
  end
  initial begin
    reset_n_i = 1'b0;
    send = 1'b0;
    word = 32'h0;
    repeat (5) @(negedge mclk_i);
    chk("reset", {1'b0, CADEC_K_NONE, 1'b0}, {dv, kind, we});
    reset_n_i <= 1'b1;
    t_moves();
    t_long();
    t_alu();
    t_selectors();
    test_done;
  end
endmodule
`default_nettype wire
